// ==== src/uib_core.sv ====
`timescale 1ns/1ps
module uib_core
#(
   parameter int RX_DEPTH = 32,
   parameter int TX_DEPTH = 16
)
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic OSCILLATOR_INPUT_PIN,
   output logic OSCILLATOR_OUTPUT_PIN,
   input wire logic EXT_CLOCK_SELECT,
   input wire logic [7:0] INTERRUPT_ENABLE_REG,
   input wire logic [7:0] FIFO_CONTROL_DATA,
   input wire logic FIFO_CONTROL_WRITE,
   input wire logic [4:0] LINE_CONTROL,
   input wire logic [7:0] DIVISOR_LOW_BYTE,
   input wire logic [7:0] DIVISOR_HIGH_BYTE,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_WRITE,
   input wire logic RX_READ,
   input wire logic STATUS_READ,
   input wire logic LINE_STATUS_READ,
   input wire logic MODEM_CHANGE,
   input wire logic FLOW_CHANGE,
   input wire logic RX_SERIAL,
   output logic TX_SERIAL,
   output logic [7:0] RECEIVE_HOLDING_REG,
   output logic [7:0] INT_STATUS,
   output logic [7:0] LINE_STATUS_REG,
   output logic INTERRUPT,
   output logic TX_DMA_REQUEST,
   output logic RX_DMA_REQUEST
);
   import uib_pkg::*;

   localparam int RCW = $clog2(RX_DEPTH) + 1;
   localparam int TCW = $clog2(TX_DEPTH) + 1;

   if (RX_DEPTH < 16 || TX_DEPTH < TX_DMA_LIMIT)
   begin
      $error("uib_core: FIFO depths too small for trigger levels");
   end

   function automatic logic [5:0] trig_level(input logic [1:0] sel);
      case (sel)
         2'h0: trig_level = TRIG_1;
         2'h1: trig_level = TRIG_4;
         2'h2: trig_level = TRIG_8;
         default: trig_level = TRIG_14;
      endcase
   endfunction

   function automatic logic [5:0] stop_ticks(input logic [4:0] lc);
      if (!lc[LCR_STOP])
         stop_ticks = TICKS_STOP_1;
      else if (lc[1:0] == 2'h0)
         stop_ticks = TICKS_STOP_15;
      else
         stop_ticks = TICKS_STOP_2;
   endfunction

   // ------------------------------------------------------------
   // Reference clock and baud generator
   // ------------------------------------------------------------
   logic osc_q_r;
   logic ref_tick;
   logic [3:0] pre_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic [DIV_W-1:0] divisor;
   logic tick_r;

   // Crystal mode uses the system oscillator, clock mode the pin.
   assign ref_tick = EXT_CLOCK_SELECT ? (OSCILLATOR_INPUT_PIN && !osc_q_r)
                                      : 1'b1;
   assign divisor = {DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE};

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         osc_q_r <= 1'b0;
         OSCILLATOR_OUTPUT_PIN <= 1'b1;
      end
      else
      begin
         osc_q_r <= OSCILLATOR_INPUT_PIN;
         OSCILLATOR_OUTPUT_PIN <= !OSCILLATOR_INPUT_PIN;
      end
   end

   // The single tick drives both the transmitter and the receiver.
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         pre_r <= 4'h0;
         div_cnt_r <= DIV_RESET;
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= 1'b0;
         if (ref_tick)
            pre_r <= pre_r + 4'h1;
         if (divisor == '0)
            div_cnt_r <= DIV_RESET;
         else if (ref_tick && pre_r == 4'(REF_DIVIDE - 1))
         begin
            if (div_cnt_r >= divisor - 16'h0001)
            begin
               div_cnt_r <= DIV_RESET;
               tick_r <= 1'b1;
            end
            else
               div_cnt_r <= div_cnt_r + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // FIFO control and buffers
   // ------------------------------------------------------------
   logic [7:0] fcr_r;
   logic rx_flush;
   logic tx_flush;
   logic rx_push;
   logic rx_in_ready;
   logic rx_valid;
   logic [7:0] rx_word;
   logic [7:0] rx_head;
   logic [RCW-1:0] rx_count;
   logic tx_in_ready;
   logic tx_valid;
   logic tx_pop;
   logic [7:0] tx_head;
   logic [TCW-1:0] tx_count;
   logic [5:0] trigger;

   assign rx_flush = FIFO_CONTROL_WRITE && FIFO_CONTROL_DATA[FCR_RX_FLUSH];
   assign tx_flush = FIFO_CONTROL_WRITE && FIFO_CONTROL_DATA[FCR_TX_FLUSH];
   assign trigger = fcr_r[FCR_FIFO_EN] ?
                    trig_level(fcr_r[FCR_TRIG_LO+:2]) : TRIG_1;

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         fcr_r <= FCR_RESET;
      else if (FIFO_CONTROL_WRITE)
         fcr_r <= FIFO_CONTROL_DATA;
   end

   uib_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo
   (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .flush(rx_flush),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .in_data(rx_word),
      .out_valid(rx_valid),
      .out_ready(RX_READ),
      .out_data(rx_head),
      .count(rx_count)
   );

   uib_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo
   (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .flush(tx_flush),
      .in_valid(TX_WRITE),
      .in_ready(tx_in_ready),
      .in_data(TX_DATA),
      .out_valid(tx_valid),
      .out_ready(tx_pop),
      .out_data(tx_head),
      .count(tx_count)
   );

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   uib_ser_t tx_st_r;
   logic [7:0] tx_sh_r;
   logic [5:0] tx_tk_r;
   logic [2:0] tx_bit_r;
   logic tx_par_r;

   assign tx_pop = tick_r && tx_st_r == SER_IDLE && tx_valid;

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         tx_st_r <= SER_IDLE;
         tx_sh_r <= 8'h00;
         tx_tk_r <= 6'h00;
         tx_bit_r <= 3'h0;
         tx_par_r <= 1'b0;
         TX_SERIAL <= 1'b1;
      end
      else if (tick_r)
      begin
         tx_tk_r <= tx_tk_r + 6'h01;
         case (tx_st_r)
            SER_IDLE:
            begin
               TX_SERIAL <= 1'b1;
               if (tx_valid)
               begin
                  tx_sh_r <= tx_head;
                  tx_par_r <= !LINE_CONTROL[LCR_PAR_EVEN];
                  tx_tk_r <= 6'h00;
                  TX_SERIAL <= 1'b0;
                  tx_st_r <= SER_START;
               end
            end
            SER_START, SER_DATA, SER_PARITY:
            begin
               if (tx_tk_r[3:0] == SAMPLES_LAST)
               begin
                  tx_tk_r <= 6'h00;
                  if (tx_st_r != SER_PARITY
                      && (tx_st_r == SER_START
                          || tx_bit_r != {1'b1, LINE_CONTROL[1:0]}))
                  begin
                     if (tx_st_r == SER_DATA)
                        tx_bit_r <= tx_bit_r + 3'h1;
                     else
                        tx_bit_r <= 3'h0;
                     TX_SERIAL <= tx_sh_r[0];
                     tx_par_r <= tx_par_r ^ tx_sh_r[0];
                     tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                     tx_st_r <= SER_DATA;
                  end
                  else if (tx_st_r == SER_DATA && LINE_CONTROL[LCR_PAR_EN])
                  begin
                     TX_SERIAL <= tx_par_r;
                     tx_st_r <= SER_PARITY;
                  end
                  else
                  begin
                     TX_SERIAL <= 1'b1;
                     tx_st_r <= SER_STOP;
                  end
               end
            end
            SER_STOP:
            begin
               // The idle tick that loads the next character ends the stop.
               if (tx_tk_r == stop_ticks(LINE_CONTROL) - 6'h02)
                  tx_st_r <= SER_IDLE;
            end
            default:
               tx_st_r <= SER_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   uib_ser_t rx_st_r;
   logic [7:0] rx_sh_r;
   logic [3:0] rx_tk_r;
   logic [2:0] rx_bit_r;
   logic rx_par_r;
   logic rx_par_err_r;
   logic rx_done_r;
   logic rx_ferr_r;
   logic stop_mid;

   assign rx_word = rx_sh_r >> (2'h3 - LINE_CONTROL[1:0]);
   assign rx_push = rx_done_r;
   assign stop_mid = tick_r && rx_st_r == SER_STOP
                     && rx_tk_r == SAMPLES_LAST;

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rx_st_r <= SER_IDLE;
         rx_sh_r <= 8'h00;
         rx_tk_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_par_r <= 1'b0;
         rx_par_err_r <= 1'b0;
         rx_done_r <= 1'b0;
         rx_ferr_r <= 1'b0;
      end
      else
      begin
         rx_done_r <= 1'b0;
         if (tick_r)
         begin
            rx_tk_r <= rx_tk_r + 4'h1;
            case (rx_st_r)
               SER_IDLE:
               begin
                  rx_tk_r <= 4'h0;
                  if (!RX_SERIAL)
                     rx_st_r <= SER_START;
               end
               SER_START:
               begin
                  if (rx_tk_r == SAMPLE_MID)
                  begin
                     rx_tk_r <= 4'h0;
                     rx_bit_r <= 3'h0;
                     rx_par_r <= !LINE_CONTROL[LCR_PAR_EVEN];
                     rx_st_r <= RX_SERIAL ? SER_IDLE : SER_DATA;
                  end
               end
               SER_DATA:
               begin
                  if (rx_tk_r == SAMPLES_LAST)
                  begin
                     rx_sh_r <= {RX_SERIAL, rx_sh_r[7:1]};
                     rx_par_r <= rx_par_r ^ RX_SERIAL;
                     rx_bit_r <= rx_bit_r + 3'h1;
                     if (rx_bit_r == {1'b1, LINE_CONTROL[1:0]})
                        rx_st_r <= LINE_CONTROL[LCR_PAR_EN] ? SER_PARITY
                                                            : SER_STOP;
                  end
               end
               SER_PARITY:
               begin
                  if (rx_tk_r == SAMPLES_LAST)
                  begin
                     rx_par_err_r <= rx_par_r != RX_SERIAL;
                     rx_st_r <= SER_STOP;
                  end
               end
               SER_STOP:
               begin
                  if (rx_tk_r == SAMPLES_LAST)
                  begin
                     rx_ferr_r <= !RX_SERIAL;
                     rx_done_r <= 1'b1;
                     rx_st_r <= SER_IDLE;
                  end
               end
               default:
                  rx_st_r <= SER_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Receive time-out
   // ------------------------------------------------------------
   logic [TIMEOUT_W-1:0] to_cnt_r;
   logic [TIMEOUT_W-1:0] to_limit;
   logic to_pend_r;

   // Four frames of start, data, parity and stop, in sample ticks.
   assign to_limit = TIMEOUT_W'(TIMEOUT_CHARS)
                     * (TIMEOUT_W'({4'(LINE_CONTROL[1:0]) + 4'h6
                                    + 4'(LINE_CONTROL[LCR_PAR_EN]), 4'h0})
                        + TIMEOUT_W'(stop_ticks(LINE_CONTROL)));

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         to_cnt_r <= '0;
         to_pend_r <= 1'b0;
      end
      else if (!rx_valid || RX_READ)
      begin
         to_cnt_r <= '0;
         to_pend_r <= 1'b0;
      end
      else if (stop_mid)
         to_cnt_r <= '0;
      else if (tick_r && !to_pend_r)
      begin
         if (to_cnt_r == to_limit - 1'b1)
            to_pend_r <= 1'b1;
         else
            to_cnt_r <= to_cnt_r + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Line status and pending sources
   // ------------------------------------------------------------
   logic overrun_r;
   logic ferr_r;
   logic perr_r;
   logic thr_pend_r;
   logic modem_pend_r;
   logic flow_pend_r;
   logic tx_empty_prev_r;
   logic [5:0] id_cur;
   logic rx_data_src;

   // Receive data source per character, per trigger only in mode 1 with the FIFOs enabled.
   assign rx_data_src = (fcr_r[FCR_DMA_MODE] && fcr_r[FCR_FIFO_EN]) ?
                        rx_count >= RCW'(trigger) : rx_valid;

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         overrun_r <= 1'b0;
         ferr_r <= 1'b0;
         perr_r <= 1'b0;
         thr_pend_r <= 1'b1;
         modem_pend_r <= 1'b0;
         flow_pend_r <= 1'b0;
         tx_empty_prev_r <= 1'b1;
      end
      else
      begin
         tx_empty_prev_r <= !tx_valid;
         // Setting events win over a clear in the same cycle.
         if (rx_done_r && !rx_in_ready)
            overrun_r <= 1'b1;
         else if (LINE_STATUS_READ)
            overrun_r <= 1'b0;
         if (rx_done_r && rx_ferr_r)
            ferr_r <= 1'b1;
         else if (LINE_STATUS_READ)
            ferr_r <= 1'b0;
         if (rx_done_r && rx_par_err_r && LINE_CONTROL[LCR_PAR_EN])
            perr_r <= 1'b1;
         else if (LINE_STATUS_READ)
            perr_r <= 1'b0;
         if (!tx_valid && !tx_empty_prev_r)
            thr_pend_r <= 1'b1;
         else if (TX_WRITE || (STATUS_READ && id_cur == ID_THR))
            thr_pend_r <= 1'b0;
         if (MODEM_CHANGE)
            modem_pend_r <= 1'b1;
         else if (STATUS_READ && id_cur == ID_MODEM)
            modem_pend_r <= 1'b0;
         if (FLOW_CHANGE)
            flow_pend_r <= 1'b1;
         else if (STATUS_READ && id_cur == ID_FLOW)
            flow_pend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupt prioritiser
   // ------------------------------------------------------------
   always_comb
   begin
      id_cur = ID_NONE;
      if (INTERRUPT_ENABLE_REG[IER_LINE] && (overrun_r || ferr_r || perr_r))
         id_cur = ID_LINE;
      else if (INTERRUPT_ENABLE_REG[IER_RX_DATA] && rx_data_src)
         id_cur = ID_RX_DATA;
      else if (INTERRUPT_ENABLE_REG[IER_RX_DATA] && to_pend_r)
         id_cur = ID_RX_TIMEOUT;
      else if (INTERRUPT_ENABLE_REG[IER_THR] && thr_pend_r)
         id_cur = ID_THR;
      else if (INTERRUPT_ENABLE_REG[IER_MODEM] && modem_pend_r)
         id_cur = ID_MODEM;
      else if ((INTERRUPT_ENABLE_REG[IER_CTS]
                || INTERRUPT_ENABLE_REG[IER_RTS]) && flow_pend_r)
         id_cur = ID_FLOW;
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         INT_STATUS <= {2'h0, ID_NONE};
         INTERRUPT <= 1'b0;
         LINE_STATUS_REG <= LSR_RESET;
         RECEIVE_HOLDING_REG <= 8'h00;
         TX_DMA_REQUEST <= 1'b0;
         RX_DMA_REQUEST <= 1'b0;
      end
      else
      begin
         INT_STATUS <= {{2{fcr_r[FCR_FIFO_EN]}}, id_cur};
         INTERRUPT <= id_cur != ID_NONE;
         LINE_STATUS_REG <= {1'b0,
                             !tx_valid && tx_st_r == SER_IDLE,
                             tx_in_ready, 1'b0, ferr_r, perr_r,
                             overrun_r, rx_valid};
         if (RX_READ && rx_valid)
            RECEIVE_HOLDING_REG <= rx_head;
         if (fcr_r[FCR_DMA_MODE] && fcr_r[FCR_FIFO_EN])
         begin
            TX_DMA_REQUEST <= tx_count < TCW'(TX_DMA_LIMIT);
            RX_DMA_REQUEST <= rx_count > RCW'(trigger);
         end
         else
         begin
            TX_DMA_REQUEST <= !tx_valid;
            RX_DMA_REQUEST <= rx_valid;
         end
      end
   end
endmodule

// ==== src/uib_pkg.sv ====
package uib_pkg;

   // ------------------------------------------------------------
   // Clock division and bit timing
   // ------------------------------------------------------------
   localparam int REF_DIVIDE = 16;
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
   localparam logic [3:0] SAMPLES_LAST = 4'hf;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [5:0] TICKS_STOP_1 = 6'h10;
   localparam logic [5:0] TICKS_STOP_15 = 6'h18;
   localparam logic [5:0] TICKS_STOP_2 = 6'h20;
   localparam int TIMEOUT_CHARS = 4;
   localparam int TIMEOUT_W = 10;

   // ------------------------------------------------------------
   // FIFO sizes and thresholds
   // ------------------------------------------------------------
   localparam int RX_FIFO_DEPTH = 32;
   localparam int TX_FIFO_DEPTH = 16;
   localparam int TX_DMA_LIMIT = 16;
   localparam logic [5:0] TRIG_1 = 6'h01;
   localparam logic [5:0] TRIG_4 = 6'h04;
   localparam logic [5:0] TRIG_8 = 6'h08;
   localparam logic [5:0] TRIG_14 = 6'h0e;

   // ------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------
   localparam int FCR_FIFO_EN = 0;
   localparam int FCR_RX_FLUSH = 1;
   localparam int FCR_TX_FLUSH = 2;
   localparam int FCR_DMA_MODE = 3;
   localparam int FCR_TRIG_LO = 6;
   localparam int IER_RX_DATA = 0;
   localparam int IER_THR = 1;
   localparam int IER_LINE = 2;
   localparam int IER_MODEM = 3;
   localparam int IER_RTS = 6;
   localparam int IER_CTS = 7;
   localparam int LCR_STOP = 2;
   localparam int LCR_PAR_EN = 3;
   localparam int LCR_PAR_EVEN = 4;
   localparam logic [7:0] FCR_RESET = 8'h00;
   localparam logic [7:0] LSR_RESET = 8'h60;

   // ------------------------------------------------------------
   // Interrupt identification codes
   // ------------------------------------------------------------
   localparam logic [5:0] ID_NONE = 6'h01;
   localparam logic [5:0] ID_LINE = 6'h06;
   localparam logic [5:0] ID_RX_DATA = 6'h04;
   localparam logic [5:0] ID_RX_TIMEOUT = 6'h0c;
   localparam logic [5:0] ID_THR = 6'h02;
   localparam logic [5:0] ID_MODEM = 6'h00;
   localparam logic [5:0] ID_FLOW = 6'h20;

   typedef enum logic [4:0] {
      SER_IDLE = 5'b00001,
      SER_START = 5'b00010,
      SER_DATA = 5'b00100,
      SER_PARITY = 5'b01000,
      SER_STOP = 5'b10000
   } uib_ser_t;

endpackage

// ==== src/uib_fifo.sv ====
`timescale 1ns/1ps
module uib_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin
      $error("uib_fifo: DEPTH must be a power of two of 2 or more");
   end

   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign count = count_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_r] <= in_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (flush)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule

// ==== sim/uib_core_sva.sv ====
`timescale 1ns/1ps
module uib_core_sva
   import uib_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] INTERRUPT_ENABLE_REG,
   input wire logic [7:0] DIVISOR_LOW_BYTE,
   input wire logic [7:0] DIVISOR_HIGH_BYTE,
   input wire logic TX_SERIAL,
   input wire logic [7:0] INT_STATUS,
   input wire logic [7:0] LINE_STATUS_REG,
   input wire logic INTERRUPT,
   input wire logic RX_DMA_REQUEST
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   wire logic [5:0] id = INT_STATUS[5:0];
   wire logic [15:0] divs = {DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE};
   property p_gate;
      INTERRUPT_ENABLE_REG == 8'h00 [*2] |-> !INTERRUPT;
   endproperty
   a_gate: assert property (p_gate) else $error("irq not gated");
   property p_thr;
      $fell(SYS_RST) && INTERRUPT_ENABLE_REG[1] |-> ##[1:2] id == ID_THR;
   endproperty
   a_thr: assert property (p_thr) else $error("no tx irq");
   property p_one;
      id != ID_NONE |-> INTERRUPT;
   endproperty
   a_one: assert property (p_one) else $error("id w/o irq");
   property p_tmo;
      $rose(id == ID_RX_TIMEOUT) |-> LINE_STATUS_REG[0];
   endproperty
   a_tmo: assert property (p_tmo) else $error("empty timeout");
   property p_lsr;
      LINE_STATUS_REG[6] |-> LINE_STATUS_REG[5];
   endproperty
   a_lsr: assert property (p_lsr) else $error("bad tx flags");
   property p_zero;
      (divs == 16'h0000) [*3] ##0 TX_SERIAL |=> TX_SERIAL;
   endproperty
   a_zero: assert property (p_zero) else $error("tick at zero");
   property p_rxd;
      RX_DMA_REQUEST |-> LINE_STATUS_REG[0];
   endproperty
   a_rxd: assert property (p_rxd) else $error("rx req empty");
   property p_rxi;
      $rose(id == ID_RX_DATA) |-> ##[0:1] LINE_STATUS_REG[0];
   endproperty
   a_rxi: assert property (p_rxi) else $error("rx irq empty");
   c_tmo: cover property (id == ID_RX_TIMEOUT);
   c_flow: cover property (id == ID_FLOW);
   c_rxd: cover property ($rose(RX_DMA_REQUEST));
endmodule
bind uib_core uib_core_sva u_sva (.*);

// ==== sim/uib_line_model.sv ====
`timescale 1ns/1ps
module uib_line_model
#(
   parameter int BIT_NS = 10240
)
(
   output logic rxd
);
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxd = f[i];
         #(BIT_NS);
      end
   endtask
endmodule

// ==== sim/test_uib_core.sv ====
`timescale 1ns/1ps
module test_uib_core;
   import uib_pkg::*;
   localparam int BIT = REF_DIVIDE * 16;
   logic SYS_CLK, SYS_RST, OSCILLATOR_INPUT_PIN, EXT_CLOCK_SELECT;
   logic FIFO_CONTROL_WRITE, TX_WRITE, RX_READ, STATUS_READ;
   logic LINE_STATUS_READ, MODEM_CHANGE, FLOW_CHANGE;
   logic OSCILLATOR_OUTPUT_PIN, TX_SERIAL, INTERRUPT;
   logic TX_DMA_REQUEST, RX_DMA_REQUEST;
   logic [7:0] INTERRUPT_ENABLE_REG, FIFO_CONTROL_DATA, TX_DATA;
   logic [7:0] DIVISOR_LOW_BYTE, DIVISOR_HIGH_BYTE, RECEIVE_HOLDING_REG;
   logic [7:0] INT_STATUS, LINE_STATUS_REG;
   logic [4:0] LINE_CONTROL;
   wire RX_SERIAL;
   int bad_count, n_tests;
   logic [7:0] q[$];
   uib_core dut (.*);
   uib_line_model #(.BIT_NS(BIT * 40)) line (.rxd(RX_SERIAL));
   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(2);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      SYS_CLK = 1'b0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   initial
   begin
      #4000000;
      bad_count++;
      complete_run;
   end
   initial
   begin
      logic [7:0] b;
      int n;
      {OSCILLATOR_INPUT_PIN, EXT_CLOCK_SELECT, FIFO_CONTROL_WRITE} = 3'b000;
      {TX_WRITE, RX_READ, STATUS_READ, LINE_STATUS_READ} = 4'h0;
      {MODEM_CHANGE, FLOW_CHANGE, TX_DATA} = 10'h000;
      {INTERRUPT_ENABLE_REG, FIFO_CONTROL_DATA} = 16'h4a49;
      {DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE} = 16'h0001;
      LINE_CONTROL = 5'h03;
      bad_count = 0;
      n_tests = 0;
      void'($urandom(20));
      SYS_RST = 1'b1;
      tick(3);
      chk(LINE_STATUS_REG, LSR_RESET);
      SYS_RST = 1'b0;
      tick(2);
      chk(INT_STATUS, {2'b00, ID_THR});
      pulse(FLOW_CHANGE);
      pulse(MODEM_CHANGE);
      chk(INT_STATUS, {2'b00, ID_THR});
      pulse(STATUS_READ);
      chk(INT_STATUS, {2'b00, ID_MODEM});
      pulse(STATUS_READ);
      chk(INT_STATUS, {2'b00, ID_FLOW});
      pulse(STATUS_READ);
      chk({INT_STATUS[6:0], INTERRUPT}, 8'h02);
      INTERRUPT_ENABLE_REG = 8'h01;
      pulse(FIFO_CONTROL_WRITE);
      for (int i = 1; i <= 5; i++)
      begin
         b = 8'($urandom);
         q.push_back(b);
         line.send(b);
         tick(4);
         chk({7'h00, RX_DMA_REQUEST}, {7'h00, i > 4});
         chk(INT_STATUS, i >= 4 ? {2'b11, ID_RX_DATA} : 8'hc1);
      end
      while (LINE_STATUS_REG[0] === 1'b1 && q.size() > 0)
      begin
         pulse(RX_READ);
         chk(RECEIVE_HOLDING_REG, q.pop_front());
      end
      chk({LINE_STATUS_REG[0], 7'(q.size())}, 8'h00);
      b = 8'($urandom);
      line.send(b);
      n = TIMEOUT_CHARS * BIT * 10 - BIT / 2;
      tick(n - 200);
      chk(INT_STATUS, 8'hc1);
      tick(300);
      chk(INT_STATUS, {2'b11, ID_RX_TIMEOUT});
      pulse(RX_READ);
      chk(RECEIVE_HOLDING_REG, b);
      chk(INT_STATUS, 8'hc1);
      INTERRUPT_ENABLE_REG = 8'h00;
      {DIVISOR_HIGH_BYTE, DIVISOR_LOW_BYTE} = 16'h0000;
      TX_WRITE = 1'b1;
      for (int i = 0; i < 17; i++)
      begin
         TX_DATA = 8'($urandom);
         if (i < 16)
            q.push_back(TX_DATA);
         tick(1);
      end
      TX_WRITE = 1'b0;
      tick(40);
      chk({TX_DMA_REQUEST, LINE_STATUS_REG[5], TX_SERIAL}, 8'h01);
      DIVISOR_LOW_BYTE = 8'h01;
      for (int i = 0; i < 16; i++)
      begin
         n = 0;
         while (TX_SERIAL !== 1'b0 && n < 5000)
         begin
            tick(1);
            n++;
         end
         tick(BIT / 2);
         for (int k = 0; k < 8; k++)
         begin
            tick(BIT);
            b[k] = TX_SERIAL;
         end
         chk(b, q.pop_front());
         tick(BIT);
      end
      tick(BIT);
      chk({TX_DMA_REQUEST, LINE_STATUS_REG[6:5]}, 8'h07);
      // In pin mode only rising pin edges may advance the bit timing.
      EXT_CLOCK_SELECT = 1'b1;
      TX_DATA = 8'($urandom);
      pulse(TX_WRITE);
      tick(40);
      chk({7'h00, TX_SERIAL}, 8'h01);
      for (int i = 0; i < 40; i++)
      begin
         OSCILLATOR_INPUT_PIN = !OSCILLATOR_INPUT_PIN;
         tick(1);
         chk({7'h00, OSCILLATOR_OUTPUT_PIN},
             {7'h00, !OSCILLATOR_INPUT_PIN});
      end
      tick(80);
      chk({7'h00, TX_SERIAL}, 8'h00);
      complete_run;
   end
endmodule
